// ===== verilog/cacr_pkg.sv
package cacr_pkg;

  // Register addresses on the plain register port
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_EDGE_POS = 8'h2c;
  localparam logic [7:0] OFF_EDGE_POS1 = 8'h2d;
  localparam logic [7:0] OFF_EDGE_POS2 = 8'h2e;
  localparam logic [7:0] OFF_FS_A_LO = 8'h30;
  localparam logic [7:0] OFF_FS_A_HI = 8'h31;
  localparam logic [7:0] OFF_FS_B_LO = 8'h32;
  localparam logic [7:0] OFF_FS_B_HI = 8'h33;
  localparam logic [7:0] OFF_REF_BYP = 8'h38;
  localparam logic [7:0] OFF_TSTP_CTL = 8'h3b;
  localparam logic [7:0] OFF_LANE_PE = 8'h48;

  // Reset values
  localparam logic [15:0] FS_RESET = 16'ha000;
  localparam logic [23:0] POS_RESET = 24'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Field positions
  localparam int unsigned BIT_REF_BYP = 0;
  localparam int unsigned BIT_RX_EN = 1 - 1;
  localparam int unsigned BIT_PECL = 1;
  localparam int unsigned BIT_PE_EXTRA = 3;
  localparam int unsigned PE_LVL_W = 3;
  localparam int unsigned NUM_LANES = 16;

  // Settings carried to the analog side
  typedef struct packed {
    logic [15:0]         fullscale_range_input_a;
    logic [15:0]         fullscale_range_input_b;
    logic                reference_bypass;
    logic                timestamp_receiver_enable;
    logic                timestamp_pecl_mode;
    logic [PE_LVL_W-1:0] lane_preemphasis_level;
    logic                lane_preemphasis_extra;
  } cacr_cfg_t;

endpackage : cacr_pkg

// ===== verilog/cacr_regs.sv
// Function
// - The block shows a 24-bit captured position of the alignment reference edge.
// - The edge position register at 0x2C is read-only and valid only after a capture.
// - Input A full-scale code is 16 bits, defaulting to 0xA000 (800 mVPP).
// - Input B full-scale code at 0x32 is separate, same coding and default.
// - Reference bypass bit 0 selects the analog core supply as reference.
// - Timestamp control bit 0 enables the timestamp receiver, clear after reset.
// - Timestamp control bit 1 selects low-voltage PECL mode.
// - Pre-emphasis level in bits 2:0 applies to all 16 serializer lanes.
// - Pre-emphasis bit 3 adds an extra boost and resets to zero.
`timescale 1ns/1ps
module cacr_regs #(
  parameter int unsigned LANES = cacr_pkg::NUM_LANES
) (
  // Clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  // Register port
  input  wire logic [cacr_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [7:0]                 o_rdata,
  // Edge position capture from the detector
  input  wire logic                       i_pos_valid,
  input  wire logic [23:0]                i_pos_value,
  output logic                            o_pos_captured,
  // Analog settings
  output cacr_pkg::cacr_cfg_t             o_cfg,
  output logic [LANES*cacr_pkg::PE_LVL_W-1:0] o_lane_pe_level,
  output logic [LANES-1:0]                o_lane_pe_extra
);

  logic [23:0] pos_r;
  logic        cap_r;
  logic [15:0] fs_a_r;
  logic [15:0] fs_b_r;
  logic        byp_r;
  logic        rx_en_r;
  logic        pecl_r;
  logic [cacr_pkg::PE_LVL_W-1:0] pe_lvl_r;
  logic        pe_ext_r;
  logic [7:0]  rdata_nxt;

  // Edge position capture, no write path from software
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pos_r <= cacr_pkg::POS_RESET;
      cap_r <= 1'b0;
    end else if (i_pos_valid) begin
      pos_r <= i_pos_value;
      cap_r <= 1'b1;
    end
  end

  // Full-scale codes, byte writable
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      fs_a_r <= cacr_pkg::FS_RESET;
      fs_b_r <= cacr_pkg::FS_RESET;
    end else if (i_wr) begin
      case (i_addr)
        cacr_pkg::OFF_FS_A_LO: fs_a_r[7:0]  <= i_wdata;
        cacr_pkg::OFF_FS_A_HI: fs_a_r[15:8] <= i_wdata;
        cacr_pkg::OFF_FS_B_LO: fs_b_r[7:0]  <= i_wdata;
        cacr_pkg::OFF_FS_B_HI: fs_b_r[15:8] <= i_wdata;
        default: ;
      endcase
    end
  end

  // Control bits; reserved bits are not stored
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      byp_r    <= 1'b0;
      rx_en_r  <= 1'b0;
      pecl_r   <= 1'b0;
      pe_lvl_r <= '0;
      pe_ext_r <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        cacr_pkg::OFF_REF_BYP: byp_r <= i_wdata[cacr_pkg::BIT_REF_BYP];
        cacr_pkg::OFF_TSTP_CTL: begin
          rx_en_r <= i_wdata[cacr_pkg::BIT_RX_EN];
          pecl_r  <= i_wdata[cacr_pkg::BIT_PECL];
        end
        cacr_pkg::OFF_LANE_PE: begin
          pe_lvl_r <= i_wdata[cacr_pkg::PE_LVL_W-1:0];
          pe_ext_r <= i_wdata[cacr_pkg::BIT_PE_EXTRA];
        end
        default: ;
      endcase
    end
  end

  // Read mux; reserved and unmapped read zero
  always_comb begin
    rdata_nxt = cacr_pkg::BYTE_RESET;
    case (i_addr)
      cacr_pkg::OFF_EDGE_POS:  rdata_nxt = pos_r[7:0];
      cacr_pkg::OFF_EDGE_POS1: rdata_nxt = pos_r[15:8];
      cacr_pkg::OFF_EDGE_POS2: rdata_nxt = pos_r[23:16];
      cacr_pkg::OFF_FS_A_LO:   rdata_nxt = fs_a_r[7:0];
      cacr_pkg::OFF_FS_A_HI:   rdata_nxt = fs_a_r[15:8];
      cacr_pkg::OFF_FS_B_LO:   rdata_nxt = fs_b_r[7:0];
      cacr_pkg::OFF_FS_B_HI:   rdata_nxt = fs_b_r[15:8];
      cacr_pkg::OFF_REF_BYP:   rdata_nxt = {7'h00, byp_r};
      cacr_pkg::OFF_TSTP_CTL:  rdata_nxt = {6'h00, pecl_r, rx_en_r};
      cacr_pkg::OFF_LANE_PE:   rdata_nxt = {4'h0, pe_ext_r, pe_lvl_r};
      default:                 rdata_nxt = cacr_pkg::BYTE_RESET;
    endcase
  end

  // Read data registered, valid only the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) o_rdata <= cacr_pkg::BYTE_RESET;
    else if (i_rd) o_rdata <= rdata_nxt;
    else o_rdata <= cacr_pkg::BYTE_RESET;
  end

  // Settings outputs
  always_comb begin
    o_cfg.fullscale_range_input_a   = fs_a_r;
    o_cfg.fullscale_range_input_b   = fs_b_r;
    o_cfg.reference_bypass          = byp_r;
    o_cfg.timestamp_receiver_enable = rx_en_r;
    o_cfg.timestamp_pecl_mode       = pecl_r;
    o_cfg.lane_preemphasis_level    = pe_lvl_r;
    o_cfg.lane_preemphasis_extra    = pe_ext_r;
  end

  assign o_pos_captured = cap_r;

  // One global setting fanned out to every lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign o_lane_pe_level[g*cacr_pkg::PE_LVL_W +: cacr_pkg::PE_LVL_W] = pe_lvl_r;
    assign o_lane_pe_extra[g] = pe_ext_r;
  end

endmodule : cacr_regs

// ===== tb/cacr_regs_asserts.sv
`timescale 1ns/1ps
module cacr_regs_asserts #(parameter int unsigned LANES = 16) (
  input logic                i_sys_clk, i_rst, i_wr, i_rd, i_pos_valid, o_pos_captured,
  input logic [7:0]          i_addr, i_wdata, o_rdata,
  input logic [23:0]         i_pos_value,
  input cacr_pkg::cacr_cfg_t o_cfg,
  input logic [LANES*3-1:0]  o_lane_pe_level,
  input logic [LANES-1:0]    o_lane_pe_extra
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_reset_vals: assert property ($past(i_rst) |-> o_cfg == {16'ha000, 16'ha000, 7'h00})
    else $error("settings not at reset values");
  a_fs_b_high: assert property (i_wr && i_addr == 8'h33 |=> o_cfg[22:15] == $past(i_wdata))
    else $error("input b code high byte not written");
  a_ref_bypass: assert property (i_wr && i_addr == 8'h38 |=> o_cfg[6] == $past(i_wdata[0]))
    else $error("reference bypass not written");
  a_tstp_bits: assert property (i_wr && i_addr == 8'h3b |=>
    {o_cfg[4], o_cfg[5]} == $past(i_wdata[1:0])) else $error("timestamp bits not written");
  a_pe_write: assert property (i_wr && i_addr == 8'h48 |=>
    o_cfg[3:0] == {$past(i_wdata[2:0]), $past(i_wdata[3])}) else $error("pre-emphasis wrong");
  a_lane_copy: assert property ({o_lane_pe_level, o_lane_pe_extra} ==
    {{LANES{o_cfg[3:1]}}, {LANES{o_cfg[0]}}}) else $error("lane copies differ");
  a_pos_read: assert property (i_pos_valid ##1 i_rd && !i_pos_valid && i_addr == 8'h2e |=>
    o_rdata == $past(i_pos_value[23:16], 2)) else $error("captured position wrong");
  a_rsvd_zero: assert property (i_rd && i_addr == 8'h3b |=> o_rdata[7:2] == 6'h00)
    else $error("reserved bits not zero");
endmodule : cacr_regs_asserts
bind cacr_regs cacr_regs_asserts #(.LANES(LANES)) u_asserts (.*);

// ===== tb/cacr_regs_tb_top.sv
`timescale 1ns/1ps
module cacr_regs_tb_top;
  logic i_sys_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_pos_valid = 1'h0, o_pos_captured;
  logic [7:0]          i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [23:0]         i_pos_value = 24'h000000;
  logic [47:0]         o_lane_pe_level;
  logic [15:0]         o_lane_pe_extra;
  cacr_pkg::cacr_cfg_t o_cfg;
  int                  error_cnt = 0, cmp_count = 0;
  cacr_regs dut (.*);
  // System clock, 10 ns period
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task chk(input string n, input logic [47:0] e, input logic [47:0] s);
    cmp_count++;
    error_cnt += (s !== e);
    if (s !== e) $display("MISMATCH %s exp %0h got %0h", n, e, s);
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, d};
    @(posedge i_sys_clk);
    {i_wr, i_rd} <= 2'h0;
    @(posedge i_sys_clk);
    if (!w) chk("rdata", d, o_rdata);
  endtask : acc
  task test_done;
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task t_reset;
    acc(1'h0, 8'h31, 8'ha0);
    acc(1'h0, 8'h33, 8'ha0);
    acc(1'h0, 8'h48, 8'h00);
    chk("captured", 48'h0, o_pos_captured);
  endtask : t_reset
  task t_write;
    logic [7:0] a [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3b, 8'h48, 8'h40};
    logic [7:0] d [8] = '{8'hff, 8'hff, 8'h00, 8'h20, 8'hff, 8'hff, 8'hff, 8'hff};
    for (int k = 0; k < 8; k++) acc(1'h1, a[k], d[k]);
    chk("fs_codes", 48'hffff2000, o_cfg[38:7]);
    acc(1'h0, 8'h38, 8'h01);
    acc(1'h0, 8'h3b, 8'h03);
    acc(1'h0, 8'h40, 8'h00);
    acc(1'h0, 8'h48, 8'h0f);
    chk("lanes", {16{3'h7}}, o_lane_pe_level);
    chk("lane_extra", 48'hffff, o_lane_pe_extra);
  endtask : t_write
  task t_capture;
    {i_pos_valid, i_pos_value} <= {1'h1, 24'h123456};
    @(posedge i_sys_clk);
    {i_pos_valid, i_pos_value} <= {1'h0, 24'hedcba9};
    acc(1'h0, 8'h2e, 8'h12);
    chk("captured", 48'h1, o_pos_captured);
    acc(1'h0, 8'h2d, 8'h34);
    acc(1'h1, 8'h2c, 8'hff);
    acc(1'h0, 8'h2c, 8'h56);
  endtask : t_capture
  // Reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    t_reset;
    t_write;
    t_capture;
    test_done;
  end
endmodule : cacr_regs_tb_top
